// >>> logic/dlts_top.sv
// How it works
// - converter loads from holding just before sync
// - advance setting moves load point earlier
// - output frame sync pulses once per frame, with the idle word when no fresh ADC word waits
// - sixteen ADC bits follow, one per clock
// - finished DAC word copied whole into holding
// - mixed mode: MSB-set frames are control, uncounted
`timescale 1ns/100ps
`default_nettype none

module dlts_top #(
  parameter int FRAME_LEN = dlts_pkg::FRAME_LEN,
  parameter int ADV_STEP = dlts_pkg::ADV_STEP,
  parameter int DEV_COUNT = dlts_pkg::DEV_COUNT,
  parameter int FIFO_DEPTH = dlts_pkg::FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SER_CLK,
  input wire logic [dlts_pkg::WORD_W-1:0] ADC_DATA,
  input wire logic ADC_VALID,
  output logic ADC_READY,
  input wire logic MIXED_MODE,
  input wire logic [dlts_pkg::ADV_W-1:0] DAC_ADVANCE,
  output logic OUTPUT_FRAME_SYNC,
  output logic SERIAL_DATA_OUT,
  input wire logic INPUT_FRAME_SYNC,
  input wire logic SERIAL_DATA_IN,
  output logic [dlts_pkg::WORD_W-1:0] DAC_WORD,
  output logic DAC_UPDATE
);
  localparam int W = dlts_pkg::WORD_W;
  localparam int CW = $clog2(FRAME_LEN);
  localparam int BW = dlts_pkg::WORD_BITS_W;

  // ****************************************
  // system clock side: fifo and word handoff
  // ****************************************
  dlts_stream_if #(.W(W)) fifo_out ();
  logic hand_req;
  logic [W-1:0] hand_word;
  logic ack_s;
  dlts_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (.clk(CLK), .rst(SYS_RST), .in_valid(ADC_VALID),
    .in_ready(ADC_READY), .in_data(ADC_DATA), .out(fifo_out.src));

  // a new word may be offered only once the link took the last one
  assign fifo_out.ready = (hand_req == ack_s);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      hand_req <= 1'b0;
      hand_word <= dlts_pkg::IDLE_ADC_WORD;
    end else if (fifo_out.valid && fifo_out.ready) begin
      hand_req <= ~hand_req;
      hand_word <= fifo_out.data;
    end
  end

  // ****************************************
  // crossings into the link domain
  // ****************************************
  logic lrst;
  logic req_s;
  logic mixed_l;
  logic [dlts_pkg::ADV_W-1:0] adv_l;
  dlts_sync #(.W(1)) u_rst_sync (.clk(SER_CLK), .rst(1'b0), .d(SYS_RST), .q(lrst));
  dlts_sync #(.W(1)) u_req_sync (.clk(SER_CLK), .rst(lrst), .d(hand_req), .q(req_s));
  // quasi-static settings, changed only between frames
  dlts_sync #(.W(dlts_pkg::ADV_W + 1)) u_cfg_sync (.clk(SER_CLK), .rst(lrst), .d({MIXED_MODE, DAC_ADVANCE}),
    .q({mixed_l, adv_l}));

  // ****************************************
  // link side: frame counter and update point
  // ****************************************
  logic [CW-1:0] fcnt;
  logic [CW-1:0] upd_slot;
  logic upd_fire;

  function automatic logic [CW-1:0] slot_of(input logic [dlts_pkg::ADV_W-1:0] adv);
    int s;
    s = FRAME_LEN - 1 - dlts_pkg::SLOT_GAP - int'(adv) * ADV_STEP;
    if (s < dlts_pkg::SLOT_MIN) begin
      s = dlts_pkg::SLOT_MIN;
    end
    return s[CW-1:0];
  endfunction

  assign upd_slot = slot_of(adv_l);
  assign upd_fire = (fcnt == upd_slot);

  always_ff @(posedge SER_CLK) begin
    if (lrst || fcnt == CW'(FRAME_LEN - 1)) begin
      fcnt <= '0;
    end else begin
      fcnt <= fcnt + 1'b1;
    end
  end

  // ****************************************
  // link side: adc word out
  // ****************************************
  dlts_pkg::dlts_tx_t tx_state;
  logic [W-1:0] tx_shift;
  logic [BW-1:0] tx_bits;
  logic ofs_q;
  logic sdo_q;
  logic ack_l;

  always_ff @(posedge SER_CLK) begin
    if (lrst) begin
      tx_state <= dlts_pkg::DLTS_TX_WAIT;
      tx_shift <= dlts_pkg::IDLE_ADC_WORD;
      tx_bits <= '0;
      ofs_q <= 1'b0;
      sdo_q <= 1'b0;
      ack_l <= 1'b0;
    end else if (fcnt == CW'(FRAME_LEN - 1)) begin
      // fresh word enters the shifter with the sync pulse
      tx_state <= dlts_pkg::DLTS_TX_SYNC;
      ofs_q <= 1'b1;
      sdo_q <= 1'b0;
      tx_bits <= '0;
      if (req_s != ack_l) begin
        tx_shift <= hand_word;
        ack_l <= req_s;
      end else begin
        tx_shift <= dlts_pkg::IDLE_ADC_WORD;
      end
    end else begin
      ofs_q <= 1'b0;
      case (tx_state)
        dlts_pkg::DLTS_TX_SYNC, dlts_pkg::DLTS_TX_SHIFT: begin
          if (tx_bits == BW'(W)) begin
            tx_state <= dlts_pkg::DLTS_TX_WAIT;
            sdo_q <= 1'b0;
          end else begin
            tx_state <= dlts_pkg::DLTS_TX_SHIFT;
            sdo_q <= tx_shift[W-1];
            tx_shift <= {tx_shift[W-2:0], 1'b0};
            tx_bits <= tx_bits + 1'b1;
          end
        end
        default: begin
          tx_state <= dlts_pkg::DLTS_TX_WAIT;
          sdo_q <= 1'b0;
        end
      endcase
    end
  end

  assign OUTPUT_FRAME_SYNC = ofs_q;
  assign SERIAL_DATA_OUT = sdo_q;

  dlts_sync #(.W(1)) u_ack_sync (.clk(CLK), .rst(SYS_RST), .d(ack_l), .q(ack_s));

  // ****************************************
  // link side: dac word in
  // ****************************************
  dlts_pkg::dlts_rx_t rx_state;
  logic [W-1:0] rx_shift;
  logic [BW-1:0] rx_bits;
  logic ifs_r;
  logic sdi_r;
  logic rx_ctrl;
  logic [W-1:0] holding;
  logic [7:0] dac_cnt;
  logic dac_pending;
  logic set_pending;

  // pins are already timed to the link clock: one capture stage
  always_ff @(posedge SER_CLK) begin
    if (lrst) begin
      ifs_r <= 1'b0;
      sdi_r <= 1'b0;
    end else begin
      ifs_r <= INPUT_FRAME_SYNC;
      sdi_r <= SERIAL_DATA_IN;
    end
  end

  always_ff @(posedge SER_CLK) begin
    if (lrst) begin
      rx_state <= dlts_pkg::DLTS_RX_IDLE;
      rx_shift <= '0;
      rx_bits <= '0;
    end else begin
      case (rx_state)
        dlts_pkg::DLTS_RX_IDLE: begin
          rx_bits <= '0;
          if (ifs_r) begin
            rx_state <= dlts_pkg::DLTS_RX_SHIFT;
          end
        end
        dlts_pkg::DLTS_RX_SHIFT: begin
          rx_shift <= {rx_shift[W-2:0], sdi_r};
          rx_bits <= rx_bits + 1'b1;
          if (rx_bits == BW'(W - 1)) begin
            rx_state <= dlts_pkg::DLTS_RX_DONE;
          end
        end
        default: begin
          rx_state <= dlts_pkg::DLTS_RX_IDLE;
        end
      endcase
    end
  end

  assign rx_ctrl = mixed_l && rx_shift[dlts_pkg::CTRL_BIT];
  assign set_pending = (rx_state == dlts_pkg::DLTS_RX_DONE) && !rx_ctrl &&
                       (dac_cnt == 8'(DEV_COUNT - 1));

  always_ff @(posedge SER_CLK) begin
    if (lrst) begin
      holding <= dlts_pkg::DAC_RESET;
      dac_cnt <= '0;
    end else if (rx_state == dlts_pkg::DLTS_RX_DONE && !rx_ctrl) begin
      holding <= rx_shift;
      dac_cnt <= set_pending ? 8'h00 : dac_cnt + 1'b1;
    end
  end

  // ****************************************
  // link side: converter update
  // ****************************************
  logic [W-1:0] conv_word;
  logic conv_tog;

  // a word finishing in the update cycle stays pending
  always_ff @(posedge SER_CLK) begin
    if (lrst) begin
      dac_pending <= 1'b0;
    end else begin
      dac_pending <= (dac_pending && !upd_fire) || set_pending;
    end
  end

  always_ff @(posedge SER_CLK) begin
    if (lrst) begin
      conv_word <= dlts_pkg::DAC_RESET;
      conv_tog <= 1'b0;
    end else if (upd_fire && dac_pending) begin
      conv_word <= holding;
      conv_tog <= ~conv_tog;
    end
  end

  // ****************************************
  // converter word back to the system clock
  // ****************************************
  logic conv_s;
  logic conv_seen;

  dlts_sync #(.W(1)) u_conv_sync (.clk(CLK), .rst(SYS_RST), .d(conv_tog), .q(conv_s));

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      conv_seen <= 1'b0;
      DAC_UPDATE <= 1'b0;
      DAC_WORD <= dlts_pkg::DAC_RESET;
    end else begin
      conv_seen <= conv_s;
      DAC_UPDATE <= (conv_s != conv_seen);
      if (conv_s != conv_seen) begin
        DAC_WORD <= conv_word;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  logic [4:0] tx_run;
  logic [4:0] rx_run;

  // run lengths of the shift states, so length checks need no long repetition
  always_ff @(posedge SER_CLK) begin
    tx_run <= (tx_state == dlts_pkg::DLTS_TX_SHIFT) ? tx_run + 1'b1 : 5'h00;
    rx_run <= (rx_state == dlts_pkg::DLTS_RX_SHIFT) ? rx_run + 1'b1 : 5'h00;
  end
  property p_default_point;
    @(posedge SER_CLK) disable iff (lrst)
    (adv_l == '0 && $changed(conv_tog)) |-> $past(fcnt) == CW'(FRAME_LEN - 2) ##1 ofs_q;
  endproperty
  a_default_point: assert property (p_default_point) else $error("default dac load not just before sync");
  property p_advance_point;
    @(posedge SER_CLK) disable iff (lrst)
    $changed(conv_tog) |-> ($past(fcnt) == $past(upd_slot)) && (conv_word == $past(holding));
  endproperty
  a_advance_point: assert property (p_advance_point) else $error("dac load off its advanced slot");
  property p_sync_pulse;
    @(posedge SER_CLK) disable iff (lrst)
    ofs_q |-> fcnt == '0 ##1 !ofs_q;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("frame sync not a one-cycle pulse at frame start");
  property p_shift_len;
    @(posedge SER_CLK) disable iff (lrst)
    ofs_q |-> ##17 (tx_state == dlts_pkg::DLTS_TX_WAIT && tx_run == 5'h10);
  endproperty
  a_shift_len: assert property (p_shift_len) else $error("adc word not sixteen clocks long");
  property p_first_bit;
    @(posedge SER_CLK) disable iff (lrst)
    ofs_q |=> sdo_q == $past(tx_shift[W-1]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first adc bit is not the msb");
  property p_capture;
    @(posedge SER_CLK) disable iff (lrst)
    (rx_state == dlts_pkg::DLTS_RX_DONE && !rx_ctrl) |=> holding == $past(rx_shift);
  endproperty
  a_capture: assert property (p_capture) else $error("dac word not copied to holding");
  property p_ctrl_skip;
    @(posedge SER_CLK) disable iff (lrst)
    (rx_state == dlts_pkg::DLTS_RX_DONE && rx_ctrl) |=> $stable(holding) && $stable(dac_cnt);
  endproperty
  a_ctrl_skip: assert property (p_ctrl_skip) else $error("control frame counted as dac word");
  property p_rx_len;
    @(posedge SER_CLK) disable iff (lrst)
    (rx_state == dlts_pkg::DLTS_RX_IDLE && ifs_r) |-> ##17 (rx_state == dlts_pkg::DLTS_RX_DONE && rx_run == 5'h10);
  endproperty
  a_rx_len: assert property (p_rx_len) else $error("dac word not sixteen bits after sync");
  property p_cv_frame;
    @(posedge SER_CLK) disable iff (lrst) ofs_q && req_s == ack_l;
  endproperty
  c_cv_frame: cover property (p_cv_frame);
  property p_cv_adv;
    @(posedge SER_CLK) disable iff (lrst) $changed(conv_tog) && adv_l != '0;
  endproperty
  c_cv_adv: cover property (p_cv_adv);
  property p_cv_ctrl;
    @(posedge SER_CLK) disable iff (lrst) rx_state == dlts_pkg::DLTS_RX_DONE && rx_ctrl;
  endproperty
  c_cv_ctrl: cover property (p_cv_ctrl);
endmodule // dlts_top

`default_nettype wire

// >>> logic/dlts_pkg.sv
package dlts_pkg;

  // ****************************************
  // word and frame layout
  // ****************************************
  localparam int WORD_W = 16;
  localparam int WORD_BITS_W = 5;
  localparam int CTRL_BIT = 15;
  localparam logic [WORD_W-1:0] DAC_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] IDLE_ADC_WORD = 16'h0000;

  // ****************************************
  // timing in link clock cycles, plus advance width, device count and fifo depth
  // ****************************************
  localparam int FRAME_LEN = 256;
  localparam int ADV_W = 3;
  localparam int ADV_STEP = 16;
  localparam int SLOT_GAP = 1;
  localparam int SLOT_MIN = 18;
  localparam int DEV_COUNT = 1;
  localparam int FIFO_DEPTH = 16;

  // ****************************************
  // state encodings
  // ****************************************
  typedef enum logic [1:0] {
    DLTS_TX_WAIT = 2'h0,
    DLTS_TX_SYNC = 2'h1,
    DLTS_TX_SHIFT = 2'h3
  } dlts_tx_t;

  typedef enum logic [1:0] {
    DLTS_RX_IDLE = 2'h0,
    DLTS_RX_SHIFT = 2'h1,
    DLTS_RX_DONE = 2'h3
  } dlts_rx_t;

endpackage

// >>> logic/dlts_stream_if.sv
`timescale 1ns/100ps
`default_nettype none

interface dlts_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// >>> logic/dlts_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// two flip-flop level synchroniser
// ****************************************
module dlts_sync #(parameter int W = 1) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // meta feeds q only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // dlts_sync

`default_nettype wire

// >>> logic/dlts_fifo.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// word fifo, power-of-two depth
// ****************************************
module dlts_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  dlts_stream_if.src out
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out.valid = (count != '0);
  assign out.data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out.valid && out.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // dlts_fifo

`default_nettype wire

// >>> testbench/dlts_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// host serial port: takes adc words, answers with queued dac words
// ****************************************
module dlts_host_model (
  input wire logic ser_clk,
  input wire logic ofs,
  input wire logic serial_data_out,
  output logic ifs,
  output logic sdi
);
  logic [15:0] dac_q[$];
  logic [15:0] rx_q[$];
  logic [15:0] sh;
  logic [15:0] tw;
  int rx_n;
  int tx_n;
  int n_ofs;
  bit go;
  realtime t_ofs;

  initial begin
    ifs = 1'b0;
    sdi = 1'b0;
    rx_n = 0;
    tx_n = 0;
    n_ofs = 0;
    go = 1'b0;
    t_ofs = 0;
  end

  always @(posedge ser_clk) begin
    #1;
    ifs = 1'b0;
    if (tx_n > 0) begin
      sdi = tw[tx_n-1];
      tx_n--;
    end else begin
      // released line must not keep showing the last bit
      sdi = ~sdi;
      if (go && dac_q.size() > 0) begin
        tw = dac_q.pop_front();
        ifs = 1'b1;
        tx_n = 16;
      end
      go = 1'b0;
    end
    if (rx_n > 0) begin
      sh = {sh[14:0], serial_data_out};
      rx_n--;
      if (rx_n == 0) begin
        rx_q.push_back(sh);
        go = 1'b1;
      end
    end
    if (ofs === 1'b1) begin
      rx_n = 16;
      n_ofs++;
      t_ofs = $realtime;
    end
  end
endmodule // dlts_host_model

`default_nettype wire

// >>> testbench/dlts_top_bench.sv
`timescale 1ns/100ps
`default_nettype none

module dlts_top_bench;
  localparam int FL = 64;
  localparam int STEP = 4;
  localparam int FNS = FL * 80;
  logic CLK, SYS_RST, SER_CLK, ADC_VALID, ADC_READY, MIXED_MODE, OUTPUT_FRAME_SYNC;
  logic SERIAL_DATA_OUT, INPUT_FRAME_SYNC, SERIAL_DATA_IN, DAC_UPDATE;
  logic [dlts_pkg::WORD_W-1:0] ADC_DATA, DAC_WORD, got, prev;
  logic [dlts_pkg::ADV_W-1:0] DAC_ADVANCE;
  logic [15:0] exp_q[$];
  int failures, n_checks, acc, e, slot;
  bit seen;
  realtime t_last;

  dlts_top #(.FRAME_LEN(FL), .ADV_STEP(STEP), .DEV_COUNT(1), .FIFO_DEPTH(16)) uut (
    .CLK(CLK), .SYS_RST(SYS_RST), .SER_CLK(SER_CLK), .ADC_DATA(ADC_DATA), .ADC_VALID(ADC_VALID),
    .ADC_READY(ADC_READY), .MIXED_MODE(MIXED_MODE), .DAC_ADVANCE(DAC_ADVANCE),
    .OUTPUT_FRAME_SYNC(OUTPUT_FRAME_SYNC), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
    .INPUT_FRAME_SYNC(INPUT_FRAME_SYNC), .SERIAL_DATA_IN(SERIAL_DATA_IN), .DAC_WORD(DAC_WORD),
    .DAC_UPDATE(DAC_UPDATE)
  );

  dlts_host_model host (
    .ser_clk(SER_CLK), .ofs(OUTPUT_FRAME_SYNC), .serial_data_out(SERIAL_DATA_OUT),
    .ifs(INPUT_FRAME_SYNC), .sdi(SERIAL_DATA_IN)
  );

  // ****************************************
  // clocks and shared tasks
  // ****************************************
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  initial begin
    SER_CLK = 1'b0;
    #13;
    forever #40 SER_CLK = ~SER_CLK;
  end

  task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
    n_checks++;
    if (seen_v !== exp_v) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wait_frame();
    int n;
    n = host.n_ofs;
    for (int i = 0; i < 4 * FL && host.n_ofs == n; i++) begin
      @(posedge CLK);
    end
    #1;
  endtask

  task automatic dac_step(input logic [15:0] v, input logic [2:0] adv, input logic mm, input logic want);
    DAC_ADVANCE = adv;
    MIXED_MODE = mm;
    wait_frame();
    wait_frame();
    prev = DAC_WORD;
    host.dac_q.push_back(v);
    seen = 1'b0;
    for (int i = 0; i < 8 * FL && !seen; i++) begin
      @(posedge CLK);
      #1;
      seen = (DAC_UPDATE === 1'b1);
    end
    check(16'(seen), 16'(want));
    check(DAC_WORD, want ? v : prev);
    if (want) begin
      slot = (FL - 2 - STEP * adv > 18) ? FL - 2 - STEP * adv : 18;
      e = ((int'($realtime - host.t_ofs) - (slot + 1) * 80) % FNS + FNS) % FNS;
      check(16'(e >= 80 && e <= 240), 16'h0001);
    end
  endtask

  // ****************************************
  // link observation
  // ****************************************
  always @(posedge CLK) begin
    if (host.rx_q.size() > 0) begin
      got = host.rx_q.pop_front();
      check(got, exp_q.size() > 0 ? exp_q.pop_front() : dlts_pkg::IDLE_ADC_WORD);
    end
  end

  always @(posedge OUTPUT_FRAME_SYNC) begin
    if (t_last > 0) begin
      check(16'(int'($realtime - t_last)), 16'(FNS));
    end
    t_last = $realtime;
  end

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    failures = 0;
    n_checks = 0;
    t_last = 0;
    SYS_RST = 1'b1;
    ADC_VALID = 1'b0;
    ADC_DATA = 16'h0000;
    MIXED_MODE = 1'b0;
    DAC_ADVANCE = 3'h0;
    void'($urandom(32'h26056c34));
    repeat (16) @(posedge CLK);
    #1;
    SYS_RST = 1'b0;
    acc = 0;
    // offer more words than the buffer holds, back to back
    for (int i = 0; i < 20; i++) begin
      ADC_DATA = 16'($urandom);
      ADC_VALID = 1'b1;
      if (ADC_READY === 1'b1) begin
        exp_q.push_back(ADC_DATA);
        acc++;
      end
      @(posedge CLK);
      #1;
    end
    check(16'(ADC_READY), 16'h0000);
    check(16'(acc >= 16 && acc <= 17), 16'h0001);
    ADC_VALID = 1'b0;
    repeat (20) wait_frame();
    check(16'(exp_q.size()), 16'h0000);
    dac_step(16'hffff, 3'h7, 1'b0, 1'b1);
    for (int a = 0; a < 8; a++) begin
      dac_step(16'($urandom), 3'(a), 1'b0, 1'b1);
    end
    dac_step(16'h8000 | 16'($urandom), 3'h0, 1'b1, 1'b0);
    dac_step(16'h7fff & 16'($urandom), 3'h5, 1'b1, 1'b1);
    end_of_test();
  end

  initial begin
    #1000000;
    failures++;
    end_of_test();
  end
endmodule // dlts_top_bench

`default_nettype wire
